// ---- logic/sgc_top.sv ----
// Global control of the serial controller with its register slave, engine and pin control.
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps

// Contract
// RL1: Software sets reset-release bit before anything else.
// RL2: Module held reset while reset-release bit is zero.
// RL3: Reserved bits read zero, writes have no effect.
// RL4: Engine disabled after reset until enable written.
// RL5: Software writes enable last, after configuration.
// RL6: Engine off forces receive and overrun flags zero.
// RL7: Engine off stops clock, forces shift register zero.
// RL8: Echo bit set enables internal self-test mode.
// RL9: Echo joins data-out to data-in when pins serial.
// RL10: Echo stores each sent word as received data; the code stores zero instead unless both pins are serial.
// RL11: Echo keeps external clock inactive, data-in undriven.
// RL12: Software selects controller role before echo mode.
// RL13: Software avoids toggling echo during a transfer.
// RL14: Software sets clock-mode bit to one.
// RL15: Software sets controller-role bit to one.
// RL16: Software writes zeroes to reserved bits.
// RL17: Disabling engine keeps configuration registers unchanged.
module sgc_top
  import sgc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_sdi,
  output logic o_sclk,
  output logic o_sdo
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic mod_release;
    logic engine_en;
    logic echo;
    logic clk_mode;
    logic role;
    logic pf_sdi;
    logic pf_sdo;
    logic [WORD_W-1:0] tx;
    logic tx_pend;
    logic [WORD_W-1:0] rx;
    logic rx_done;
    logic overrun;
    logic sdi_meta;
    logic sdi_sync;
    logic sclk;
    logic sdo;
    logic waitrq;
    logic [31:0] rdata;
  } sgc_state_t;

  sgc_state_t s_q;
  sgc_state_t s_d;

  logic run;
  logic echo_link;
  logic accept;
  logic wr;
  logic rx_clear;
  logic ovr_clear;
  logic [31:0] rd_word;
  logic [31:0] merged;
  logic shf_start;
  logic shf_rx_bit;
  logic shf_tick;
  logic shf_busy;
  logic shf_done;
  logic shf_sclk;
  logic shf_sdo;
  logic [WORD_W-1:0] shf_rx_word;

  function automatic logic [31:0] sgc_merge(input logic [31:0] old_word,
                                            input logic [31:0] wdata,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_word & ~m) | (wdata & m);
  endfunction : sgc_merge

  // ****************************************************************
  // Engine
  // ****************************************************************
  sgc_clk_div u_div (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_run(shf_busy),
    .o_tick(shf_tick)
  );

  sgc_shifter u_shf (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_run(run),
    .i_tick(shf_tick),
    .i_start(shf_start),
    .i_data(s_q.tx),
    .i_rx_bit(shf_rx_bit),
    .o_busy(shf_busy),
    .o_done(shf_done),
    .o_sclk(shf_sclk),
    .o_sdo(shf_sdo),
    .o_rx_word(shf_rx_word)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    rd_word = REG_RESET;
    accept = 1'b0;
    rx_clear = 1'b0;
    ovr_clear = 1'b0;
    shf_start = 1'b0;
    run = s_q.mod_release & s_q.engine_en; // RL2 RL4
    echo_link = s_q.echo & s_q.pf_sdi & s_q.pf_sdo;
    // The pin is disconnected in echo mode; without serial pins nothing is looped.
    shf_rx_bit = s_q.echo ? (echo_link & shf_sdo) : (s_q.pf_sdi & s_q.sdi_sync); // RL9 RL10
    s_d.sdi_meta = i_sdi;
    s_d.sdi_sync = s_q.sdi_meta;

    // Readback keeps every reserved position at zero.
    case (i_address)
      OFS_MODULE_RESET: rd_word[RELEASE_BIT] = s_q.mod_release; // RL3
      OFS_GLOBAL_MODE:
      begin
        rd_word[ENABLE_BIT] = s_q.engine_en;
        rd_word[ECHO_BIT] = s_q.echo;
        rd_word[CLKMODE_BIT] = s_q.clk_mode;
        rd_word[ROLE_BIT] = s_q.role;
      end
      OFS_FLAG:
      begin
        rd_word[RXDONE_BIT] = s_q.rx_done;
        rd_word[OVERRUN_BIT] = s_q.overrun;
        rd_word[BUSY_BIT] = shf_busy;
      end
      OFS_PIN_FUNC:
      begin
        rd_word[PF_SDI_BIT] = s_q.pf_sdi;
        rd_word[PF_SDO_BIT] = s_q.pf_sdo;
      end
      OFS_TX: rd_word[WORD_W-1:0] = s_q.tx;
      OFS_RX: rd_word[WORD_W-1:0] = s_q.rx;
      default: rd_word = REG_RESET;
    endcase
    merged = sgc_merge(rd_word, i_writedata, i_byteenable);

    // One wait cycle, then a single ready cycle in which the access completes.
    if (s_q.waitrq)
    begin
      if (i_read || i_write)
      begin
        s_d.waitrq = 1'b0;
        s_d.rdata = i_read ? rd_word : REG_RESET;
      end
    end
    else
    begin
      s_d.waitrq = 1'b1;
      accept = i_read || i_write;
    end
    wr = accept & i_write;

    // A queued word starts before any write of this cycle refills the holding register.
    if (run && s_q.tx_pend && !shf_busy)
    begin
      shf_start = 1'b1;
      s_d.tx_pend = 1'b0;
    end

    if (wr)
    begin
      case (i_address)
        OFS_MODULE_RESET: s_d.mod_release = merged[RELEASE_BIT]; // RL3
        OFS_GLOBAL_MODE:
          if (s_q.mod_release)
          begin
            s_d.engine_en = merged[ENABLE_BIT]; // RL4
            s_d.echo = merged[ECHO_BIT]; // RL8
            s_d.clk_mode = merged[CLKMODE_BIT];
            s_d.role = merged[ROLE_BIT];
          end
        OFS_FLAG:
        begin
          rx_clear = i_byteenable[0] & i_writedata[RXDONE_BIT];
          ovr_clear = i_byteenable[0] & i_writedata[OVERRUN_BIT];
        end
        OFS_PIN_FUNC:
          if (s_q.mod_release)
          begin
            s_d.pf_sdi = merged[PF_SDI_BIT];
            s_d.pf_sdo = merged[PF_SDO_BIT];
          end
        OFS_TX:
          if (run)
          begin
            s_d.tx = merged[WORD_W-1:0];
            s_d.tx_pend = 1'b1;
          end
        default: ;
      endcase
    end
    if (accept && i_read && (i_address == OFS_RX))
      rx_clear = 1'b1;

    // Clears first so that a word finishing in the same cycle still sets its flags.
    if (rx_clear)
      s_d.rx_done = 1'b0;
    if (ovr_clear)
      s_d.overrun = 1'b0;
    if (shf_done)
    begin
      s_d.rx = shf_rx_word; // RL10
      s_d.rx_done = 1'b1;
      if (s_q.rx_done && !rx_clear)
        s_d.overrun = 1'b1;
    end

    // Engine or module off clears the working state; only a module reset clears config.
    if (!run || !s_d.mod_release)
    begin
      s_d.rx_done = 1'b0; // RL6
      s_d.overrun = 1'b0; // RL6
      s_d.tx = '0; // RL7 RL17
      s_d.tx_pend = 1'b0;
    end
    if (!s_d.mod_release)
    begin
      s_d.engine_en = 1'b0; // RL2
      s_d.echo = 1'b0;
      s_d.clk_mode = 1'b0;
      s_d.role = 1'b0;
      s_d.pf_sdi = 1'b0;
      s_d.pf_sdo = 1'b0;
      s_d.rx = '0;
    end

    // Pins sit at their inactive level whenever the engine is off or echoing.
    s_d.sclk = (run && s_d.mod_release && !s_q.echo) ? shf_sclk : 1'b0; // RL7 RL11
    s_d.sdo = (run && s_d.mod_release && !s_q.echo && s_q.pf_sdo) ? shf_sdo : 1'b0; // RL11
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_q <= '0;
      s_q.waitrq <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_readdata = s_q.rdata;
  assign o_waitrequest = s_q.waitrq;
  assign o_sclk = s_q.sclk;
  assign o_sdo = s_q.sdo;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  // Records the word handed to the engine and whether the echo loop (echo with both pins serial) stayed closed throughout.
  logic [WORD_W-1:0] h_sent;
  logic h_echo_all;

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      h_sent <= '0;
      h_echo_all <= 1'b0;
    end
    else if (shf_start)
    begin
      h_sent <= s_q.tx;
      h_echo_all <= echo_link;
    end
    else if (!echo_link)
      h_echo_all <= 1'b0;
  end

  property p_release_holds;
    !s_q.mod_release |-> !s_q.engine_en && !s_q.echo && !o_sclk && !s_q.rx_done;
  endproperty
  a_release_holds: assert property (p_release_holds) else $error("config live in reset"); // RL2

  property p_reserved_global;
    (!o_waitrequest && i_read && i_address == OFS_GLOBAL_MODE)
      |-> (o_readdata & ~GMC_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved_global: assert property (p_reserved_global) else $error("reserved bit set"); // RL3

  property p_reserved_reset;
    (!o_waitrequest && i_read && i_address == OFS_MODULE_RESET)
      |-> o_readdata[31:1] == 31'h0000_0000;
  endproperty
  a_reserved_reset: assert property (p_reserved_reset) else $error("reserved bit set"); // RL3

  property p_enable_by_write;
    $rose(s_q.engine_en) |-> $past(wr && i_address == OFS_GLOBAL_MODE
                                   && i_byteenable[3] && i_writedata[ENABLE_BIT]);
  endproperty
  a_enable_by_write: assert property (p_enable_by_write) else $error("enable not written"); // RL4

  property p_flags_forced;
    !run |=> !s_q.rx_done && !s_q.overrun;
  endproperty
  a_flags_forced: assert property (p_flags_forced) else $error("flag set while off"); // RL6

  property p_engine_off_pins;
    !run |=> s_q.tx == '0 && !o_sclk ##1 !o_sclk && !o_sdo;
  endproperty
  a_engine_off_pins: assert property (p_engine_off_pins) else $error("engine not held"); // RL7

  property p_echo_isolates;
    s_q.echo |=> !o_sclk && !o_sdo;
  endproperty
  a_echo_isolates: assert property (p_echo_isolates) else $error("pins active in echo"); // RL11

  property p_echo_data;
    (shf_done && h_echo_all && s_d.mod_release) |=> s_q.rx == h_sent && s_q.rx_done;
  endproperty
  a_echo_data: assert property (p_echo_data) else $error("echo word mismatch"); // RL10

  property p_config_kept;
    (!run && s_q.mod_release && s_d.mod_release && !(wr && i_address == OFS_GLOBAL_MODE))
      |=> $stable(s_q.clk_mode) && $stable(s_q.role) && $stable(s_q.echo);
  endproperty
  a_config_kept: assert property (p_config_kept) else $error("config lost"); // RL17

  property p_overrun_set;
    (shf_done && s_q.rx_done && !rx_clear && run && s_d.mod_release) |=> s_q.overrun;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun missed");

  property p_bus_answer;
    ((i_read || i_write) && o_waitrequest) |=> !o_waitrequest ##1 o_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  c_echo_word: cover property (shf_done && h_echo_all);
  c_overrun: cover property (shf_done && s_q.rx_done && run);
  c_disable: cover property ($fell(s_q.engine_en) && s_q.mod_release);
  c_release: cover property ($rose(s_q.mod_release));

endmodule : sgc_top

// ---- logic/sgc_pkg.sv ----
// Package with register map, field positions and timing counts of the serial global control.
package sgc_pkg;

  // ****************************************************************
  // Register offsets (byte addresses on the register bus)
  // ****************************************************************
  localparam int ADDR_W = 7;
  localparam logic [6:0] OFS_MODULE_RESET = 7'h00;
  localparam logic [6:0] OFS_GLOBAL_MODE = 7'h04;
  localparam logic [6:0] OFS_FLAG = 7'h10;
  localparam logic [6:0] OFS_PIN_FUNC = 7'h14;
  localparam logic [6:0] OFS_TX = 7'h3C;
  localparam logic [6:0] OFS_RX = 7'h40;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RELEASE_BIT = 0;
  localparam int ROLE_BIT = 0;
  localparam int CLKMODE_BIT = 1;
  localparam int ECHO_BIT = 16;
  localparam int ENABLE_BIT = 24;
  localparam int RXDONE_BIT = 0;
  localparam int OVERRUN_BIT = 1;
  localparam int BUSY_BIT = 2;
  localparam int PF_SDI_BIT = 0;
  localparam int PF_SDO_BIT = 1;

  // ****************************************************************
  // Writable and readable masks and reset values
  // ****************************************************************
  localparam logic [31:0] MRC_WMASK = 32'h0000_0001;
  localparam logic [31:0] GMC_WMASK = 32'h0101_0003;
  localparam logic [31:0] FLAG_RMASK = 32'h0000_0007;
  localparam logic [31:0] PF_WMASK = 32'h0000_0003;
  localparam logic [31:0] WORD_RMASK = 32'h0000_FFFF;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ****************************************************************
  // Serial word and clock timing
  // ****************************************************************
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam logic [4:0] LAST_BIT = 5'h0F;
  localparam int DIV_W = 3;
  // Half period of the serial clock in system clock cycles.
  localparam logic [2:0] HALF_PERIOD_CYCLES = 3'h4;
  localparam logic [2:0] HALF_PERIOD_LAST = HALF_PERIOD_CYCLES - 3'h1;

endpackage : sgc_pkg

// ---- logic/sgc_clk_div.sv ----
// Divider that makes the serial clock half-period enable pulse.
`timescale 1ns/1ps
module sgc_clk_div
  import sgc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_run,
  output logic o_tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } sgc_div_t;

  sgc_div_t s_q;
  sgc_div_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!i_run)
    begin
      s_d.cnt = '0;
    end
    else if (s_q.cnt == HALF_PERIOD_LAST)
    begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 3'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule : sgc_clk_div

// ---- logic/sgc_shifter.sv ----
// Serial shift engine: one word out MSB first, sampled on the rising serial clock edge.
`timescale 1ns/1ps
module sgc_shifter
  import sgc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic [WORD_W-1:0] i_data,
  input wire logic i_rx_bit,
  output logic o_busy,
  output logic o_done,
  output logic o_sclk,
  output logic o_sdo,
  output logic [WORD_W-1:0] o_rx_word
);

  typedef struct packed {
    logic [WORD_W-1:0] tx;
    logic [WORD_W-1:0] rx;
    logic [CNT_W-1:0] cnt;
    logic sclk;
    logic busy;
    logic done;
  } sgc_shf_t;

  sgc_shf_t s_q;
  sgc_shf_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!i_run)
    begin
      // Held in reset: shift register forced to zero, clock idle.
      s_d = '0; // RL7
    end
    else if (!s_q.busy)
    begin
      if (i_start)
      begin
        s_d.tx = i_data;
        s_d.cnt = '0;
        s_d.busy = 1'b1;
      end
    end
    else if (i_tick)
    begin
      if (!s_q.sclk)
      begin
        s_d.sclk = 1'b1;
        s_d.rx = {s_q.rx[WORD_W-2:0], i_rx_bit};
      end
      else
      begin
        s_d.sclk = 1'b0;
        s_d.tx = {s_q.tx[WORD_W-2:0], 1'b0};
        if (s_q.cnt == LAST_BIT)
        begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_busy = s_q.busy;
  assign o_done = s_q.done;
  assign o_sclk = s_q.sclk;
  assign o_sdo = s_q.tx[WORD_W-1];
  assign o_rx_word = s_q.rx;

endmodule : sgc_shifter

// ---- test/sgc_target_model.sv ----
// Behavioural serial target that answers with a reply word and captures the word it receives.
`timescale 1ns/1ps
module sgc_target_model
(
  input wire logic i_resetn,
  input wire logic i_sclk,
  input wire logic i_sdo,
  input wire logic [15:0] i_reply,
  output logic o_sdi,
  output logic [15:0] o_captured,
  output int o_rises
);
  logic [3:0] bit_idx = 4'hF;

  initial
  begin
    o_captured = 16'h0000;
    o_rises = 0;
  end

  // Edges seen while the controller is in reset are ignored, since the pin may leave X then.
  always @(posedge i_sclk)
  begin
    if (i_resetn === 1'b1)
    begin
      o_captured <= {o_captured[14:0], i_sdo};
      o_rises <= o_rises + 1;
    end
  end

  // The index wraps after sixteen falls, so every word starts again from its top bit.
  always @(negedge i_sclk)
  begin
    if (i_resetn !== 1'b1)
      bit_idx <= 4'hF;
    else
      bit_idx <= bit_idx - 4'h1;
  end

  assign o_sdi = i_reply[bit_idx];
endmodule : sgc_target_model

// ---- test/tb.sv ----
// Self-checking testbench of the serial global control block.
`timescale 1ns/1ps
module tb;
  import sgc_pkg::*;
  logic i_clock, i_resetn, i_read, i_write, i_sdi, o_waitrequest, o_sclk, o_sdo, echo_on;
  logic [ADDR_W-1:0] i_address;
  logic [31:0] i_writedata, o_readdata, rd, tx;
  logic [3:0] i_byteenable;
  logic [15:0] reply, captured, exp_rx;
  int rises, miscompares, num_checks, cycles, sdo_highs, words;

  sgc_top DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_sdi(i_sdi), .o_sclk(o_sclk), .o_sdo(o_sdo));

  sgc_target_model target (.i_resetn(i_resetn), .i_sclk(o_sclk), .i_sdo(o_sdo),
    .i_reply(reply), .o_sdi(i_sdi), .o_captured(captured), .o_rises(rises));

  // ****************************************************************
  // Clock, timeout and pin monitor
  // ****************************************************************
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  // A hung handshake would otherwise stall the run forever; a poll gives up after 300 retries.
  always @(posedge i_clock)
  begin
    cycles++;
    if (echo_on && o_sdo === 1'b1)
      sdo_highs++;
    if (cycles == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Waitrequest and readdata are read right at the rising edge, before the design's registers
  // update, so the values are the ones that edge samples; the request stands until then.
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_read <= ~wr;
    i_write <= wr;
    i_address <= a;
    i_writedata <= d;
    @(posedge i_clock);
    while (o_waitrequest !== 1'b0)
      @(posedge i_clock);
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask : bus

  task automatic rdchk(input string what, input logic [6:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(what, exp, rd);
  endtask : rdchk

  task automatic poll(input logic [31:0] mask, input logic [31:0] want);
    int n;
    n = 0;
    bus(1'b0, OFS_FLAG, 32'h0000_0000);
    while ((rd & mask) !== want && n < 300)
    begin
      bus(1'b0, OFS_FLAG, 32'h0000_0000);
      n++;
    end
  endtask : poll

  // The reference model expects the target's reply in normal mode, the sent word in echo with serial pins, and zero in echo without them.
  task automatic send(input logic pins_serial);
    tx = {16'h0000, 16'($urandom)};
    reply <= 16'($urandom);
    bus(1'b1, OFS_TX, tx);
    words++;
    exp_rx = echo_on ? (pins_serial ? tx[15:0] : 16'h0000) : reply;
    poll(32'h0000_0005, 32'h0000_0001);
  endtask : send

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {i_resetn, i_read, i_write, echo_on} = 4'h0;
    i_address = '0;
    i_writedata = 32'h0000_0000;
    i_byteenable = 4'hF;
    reply = 16'h0000;
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    sdo_highs = 0;
    words = 0;
    void'($urandom(32'hac26c4ed));
    repeat (10) @(posedge i_clock);
    i_resetn <= 1'b1;
    check("sclk idle", 32'h0, {31'h0, o_sclk});
    rdchk("reset ctrl", OFS_MODULE_RESET, 32'h0000_0000);
    rdchk("mode after reset", OFS_GLOBAL_MODE, 32'h0000_0000);
    bus(1'b1, OFS_GLOBAL_MODE, 32'h0100_0003);
    rdchk("mode held in reset", OFS_GLOBAL_MODE, 32'h0000_0000);
    bus(1'b1, OFS_MODULE_RESET, $urandom | 32'h0000_0001);
    rdchk("reset ctrl reserved", OFS_MODULE_RESET, 32'h0000_0001);
    rdchk("unmapped", 7'h08, 32'h0000_0000);
    bus(1'b1, OFS_GLOBAL_MODE, 32'hFEFE_0003);
    rdchk("mode reserved", OFS_GLOBAL_MODE, 32'h0000_0003);
    bus(1'b1, OFS_TX, 32'h0000_A5C3);
    rdchk("tx while off", OFS_TX, 32'h0000_0000);
    repeat (100) @(posedge i_clock);
    check("sclk edges while off", 32'd0, 32'(rises));
    bus(1'b1, OFS_PIN_FUNC, 32'h0000_0003);
    bus(1'b1, OFS_GLOBAL_MODE, 32'h0100_0003);
    rdchk("mode enabled", OFS_GLOBAL_MODE, 32'h0100_0003);
    repeat (2)
    begin
      send(1'b1);
      check("target capture", tx, {16'h0000, captured});
      check("sclk rises", 32'(16 * words), 32'(rises));
      rdchk("rx word", OFS_RX, {16'h0000, exp_rx});
      rdchk("flag after rx read", OFS_FLAG, 32'h0000_0000);
    end
    send(1'b1);
    send(1'b1);
    poll(32'h0000_0002, 32'h0000_0002);
    check("overrun flags", 32'h0000_0003, rd & 32'h0000_0003);
    bus(1'b1, OFS_GLOBAL_MODE, 32'h0000_0003);
    rdchk("flags when off", OFS_FLAG, 32'h0000_0000);
    rdchk("config kept", OFS_GLOBAL_MODE, 32'h0000_0003);
    rdchk("tx forced", OFS_TX, 32'h0000_0000);
    bus(1'b1, OFS_PIN_FUNC, 32'h0000_0003);
    bus(1'b1, OFS_GLOBAL_MODE, 32'h0101_0003);
    rdchk("echo mode", OFS_GLOBAL_MODE, 32'h0101_0003);
    echo_on = 1'b1;
    sdo_highs = 0;
    send(1'b1);
    check("echo sclk quiet", 32'(16 * (words - 1)), 32'(rises));
    check("echo sdo quiet", 32'd0, 32'(sdo_highs));
    rdchk("echo rx", OFS_RX, {16'h0000, exp_rx});
    bus(1'b1, OFS_PIN_FUNC, 32'h0000_0000);
    send(1'b0);
    rdchk("echo pins off", OFS_RX, {16'h0000, exp_rx});
    echo_on = 1'b0;
    bus(1'b1, OFS_GLOBAL_MODE, 32'h0000_0003);
    bus(1'b1, OFS_PIN_FUNC, 32'h0000_0003);
    bus(1'b1, OFS_MODULE_RESET, 32'h0000_0000);
    rdchk("mode cleared", OFS_GLOBAL_MODE, 32'h0000_0000);
    rdchk("pins cleared", OFS_PIN_FUNC, 32'h0000_0000);
    give_verdict();
  end
endmodule : tb
